// ### phy_mgmt_pkg.sv
// shared constants and types for the phy management event, diagnostic and led registers
// How it works
// - receive error sets event bit 6, held until a read clears it.
// - new page from partner during negotiation sets event bit 5.
// - parallel detection fault during negotiation sets event bit 4.
// - burst with partner acknowledge bit during negotiation sets event bit 3.
// - link going good to failed sets event bit 2; failed to good does not.
// - partner signalling remote fault sets event bit 1.
// - successful end of negotiation sets event bit 0.
// - any read of the event register clears the eight low event flags, except a flag whose event arrives in the same cycle.
// - upper byte enables let matching low byte flags raise the phy interrupt.
// - read-only diagnostic register, reset zero, reports last negotiation outcome.
// - writable transceiver gain register, reset with only bit 14 set.
// - bits 7:4 of led register pick second lamp source, reset 0x1.
// - bits 3:0 of led register pick first lamp source, reset 0x0.
// - source codes: link, activity, 100 mode, 10 mode, duplex, link blink; 2-4 reserved.
// - led register upper byte reads zero; software preserves it.
// - led register writable, resets to 0x0010.
package phy_mgmt_pkg;

  // register addresses on the management port
  localparam logic [4:0] ADDR_EVENT = 5'h11;
  localparam logic [4:0] ADDR_DIAG = 5'h12;
  localparam logic [4:0] ADDR_GAIN = 5'h13;
  localparam logic [4:0] ADDR_LED = 5'h17;

  // event flag positions in the low byte
  localparam int BIT_JABBER = 7;
  localparam int BIT_RX_ERROR = 6;
  localparam int BIT_PAGE = 5;
  localparam int BIT_PAR_FAULT = 4;
  localparam int BIT_PARTNER_ACK = 3;
  localparam int BIT_LINK_CHANGE = 2;
  localparam int BIT_REMOTE_FAULT = 1;
  localparam int BIT_NEG_DONE = 0;
  localparam int FLAG_W = 8;

  // diagnostic field positions
  localparam int DIAG_NEG_FAIL = 12;
  localparam int DIAG_DUPLEX = 11;
  localparam int DIAG_RATE = 10;
  localparam int DIAG_RX_SIGNAL = 9;
  localparam int DIAG_RX_LOCK = 8;

  // reset values
  localparam logic [15:0] GAIN_RESET = 16'h4000;
  localparam logic [7:0] LED_RESET = 8'h10;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [15:0] RDATA_ZERO = 16'h0000;

  // lamp source codes
  localparam int LED_FIELD_W = 4;
  localparam int LAMP_COUNT = 2;
  localparam logic [3:0] LED_SRC_LINK = 4'h0;
  localparam logic [3:0] LED_SRC_ACTIVITY = 4'h1;
  localparam logic [3:0] LED_SRC_RSVD2 = 4'h2;
  localparam logic [3:0] LED_SRC_100 = 4'h5;
  localparam logic [3:0] LED_SRC_10 = 4'h6;
  localparam logic [3:0] LED_SRC_DUPLEX = 4'h7;
  localparam logic [3:0] LED_SRC_LINK_BLINK = 4'h8;

  // blink half period for the link-blink source
  localparam int CLK_KHZ = 20000;
  localparam int BLINK_HALF_MS = 50;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_KHZ;

  // event pulses from the receive, link and negotiation logic
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_received;
    logic parallel_fault;
    logic partner_ack;
    logic remote_fault;
    logic negotiation_done;
  } phy_events_t;

  // live link state levels
  typedef struct packed {
    logic link_ok;
    logic activity;
    logic speed_100;
    logic speed_10;
    logic full_duplex;
  } link_state_t;

  // negotiation outcome levels
  typedef struct packed {
    logic neg_failed;
    logic best_duplex;
    logic best_rate;
    logic rx_signal;
    logic rx_lock;
  } diag_state_t;

endpackage : phy_mgmt_pkg

// ### led_source_mux.sv
// lamp source selector for one status lamp
`timescale 1ns/1ps
module led_source_mux
(
  // source choice
  input wire logic [3:0] sel,
  // link state and blink phase
  input wire phy_mgmt_pkg::link_state_t link,
  input wire logic blink_phase,
  // chosen lamp level
  output logic lamp_on
);

  // decode the source code, reserved codes keep the lamp dark
  wire is_link = (sel == phy_mgmt_pkg::LED_SRC_LINK);
  wire is_act = (sel == phy_mgmt_pkg::LED_SRC_ACTIVITY);
  wire is_100 = (sel == phy_mgmt_pkg::LED_SRC_100);
  wire is_10 = (sel == phy_mgmt_pkg::LED_SRC_10);
  wire is_dup = (sel == phy_mgmt_pkg::LED_SRC_DUPLEX);
  wire is_blink = (sel == phy_mgmt_pkg::LED_SRC_LINK_BLINK);
  wire blink_level = link.link_ok & ~(link.activity & blink_phase);

  // select one source
  assign lamp_on = (is_link & link.link_ok) | (is_act & link.activity) | (is_100 & link.speed_100)
                 | (is_10 & link.speed_10) | (is_dup & link.full_duplex) | (is_blink & blink_level);

endmodule : led_source_mux

// ### phy_mgmt_event_diag_led_regs.sv
// phy management event flags, diagnostic, gain and lamp source registers
`timescale 1ns/1ps
module phy_mgmt_event_diag_led_regs
#(
  parameter int BLINK_HALF_CYCLES = phy_mgmt_pkg::BLINK_HALF_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // management port
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_rd,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // phy side status
  input wire phy_mgmt_pkg::phy_events_t events,
  input wire phy_mgmt_pkg::link_state_t link,
  input wire phy_mgmt_pkg::diag_state_t diag,
  // interrupt toward the mac, raised only by flags whose enable bit is set
  output logic phy_irq,
  // transceiver gain setting
  output logic [15:0] tx_gain_setting,
  // status lamps
  output logic status_lamp_a,
  output logic status_lamp_b
);

  localparam int BLINK_W = $clog2(BLINK_HALF_CYCLES + 1);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF_CYCLES - 1);
  localparam logic [BLINK_W-1:0] BLINK_ZERO = '0;

  // register state
  logic [7:0] event_flags;
  logic [7:0] irq_enable;
  logic [15:0] gain;
  logic [7:0] led_cfg;
  logic neg_fail_flag;
  phy_mgmt_pkg::diag_state_t diag_live;
  logic link_q;
  logic [BLINK_W-1:0] blink_cnt;
  logic blink_phase;

  // address decode
  wire sel_event = (mgmt_addr == phy_mgmt_pkg::ADDR_EVENT);
  wire sel_diag = (mgmt_addr == phy_mgmt_pkg::ADDR_DIAG);
  wire sel_gain = (mgmt_addr == phy_mgmt_pkg::ADDR_GAIN);
  wire sel_led = (mgmt_addr == phy_mgmt_pkg::ADDR_LED);
  wire rd_event = mgmt_rd & sel_event;
  wire rd_diag = mgmt_rd & sel_diag;
  wire wr_event = mgmt_wr & sel_event;
  wire wr_gain = mgmt_wr & sel_gain;
  wire wr_led = mgmt_wr & sel_led;

  // link failure edge, a rise does nothing
  wire link_fall = link_q & ~link.link_ok;

  // event hits mapped to their flag positions
  wire [7:0] event_hits;
  assign event_hits[phy_mgmt_pkg::BIT_JABBER] = events.jabber;
  assign event_hits[phy_mgmt_pkg::BIT_RX_ERROR] = events.rx_error;
  assign event_hits[phy_mgmt_pkg::BIT_PAGE] = events.page_received;
  assign event_hits[phy_mgmt_pkg::BIT_PAR_FAULT] = events.parallel_fault;
  assign event_hits[phy_mgmt_pkg::BIT_PARTNER_ACK] = events.partner_ack;
  assign event_hits[phy_mgmt_pkg::BIT_LINK_CHANGE] = link_fall;
  assign event_hits[phy_mgmt_pkg::BIT_REMOTE_FAULT] = events.remote_fault;
  assign event_hits[phy_mgmt_pkg::BIT_NEG_DONE] = events.negotiation_done;

  // read clears, a new event in the same cycle wins
  wire [7:0] flag_keep = rd_event ? phy_mgmt_pkg::FLAG_RESET : event_flags;
  wire [7:0] next_flags = flag_keep | event_hits;
  wire next_neg_fail = (neg_fail_flag & ~rd_diag) | diag.neg_failed;

  // enables gate flags onto the interrupt
  wire next_irq = |(next_flags & irq_enable);

  // read views of each register
  wire [15:0] event_view = {irq_enable, event_flags};
  wire [15:0] diag_view = ({15'h0000, neg_fail_flag} << phy_mgmt_pkg::DIAG_NEG_FAIL)
                        | ({15'h0000, diag_live.best_duplex} << phy_mgmt_pkg::DIAG_DUPLEX)
                        | ({15'h0000, diag_live.best_rate} << phy_mgmt_pkg::DIAG_RATE)
                        | ({15'h0000, diag_live.rx_signal} << phy_mgmt_pkg::DIAG_RX_SIGNAL)
                        | ({15'h0000, diag_live.rx_lock} << phy_mgmt_pkg::DIAG_RX_LOCK);
  wire [15:0] led_view = {8'h00, led_cfg};

  // read data select, unmapped addresses read zero
  wire [15:0] next_rdata = sel_event ? event_view :
                           sel_diag ? diag_view :
                           sel_gain ? gain :
                           sel_led ? led_view : phy_mgmt_pkg::RDATA_ZERO;

  // blink counter wrap
  wire blink_wrap = (blink_cnt == BLINK_LAST);
  wire [BLINK_W-1:0] next_blink_cnt = blink_wrap ? BLINK_ZERO : blink_cnt + BLINK_W'(1);

  // lamp source selection per lamp
  wire [phy_mgmt_pkg::LAMP_COUNT-1:0] next_lamp;
  genvar gi;
  generate
    for (gi = 0; gi < phy_mgmt_pkg::LAMP_COUNT; gi = gi + 1)
    begin : g_lamp
      led_source_mux u_mux
      (
        .sel(led_cfg[gi*phy_mgmt_pkg::LED_FIELD_W +: phy_mgmt_pkg::LED_FIELD_W]),
        .link(link),
        .blink_phase(blink_phase),
        .lamp_on(next_lamp[gi])
      );
    end
  endgenerate

  // event flags and interrupt; low byte writes are ignored
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      event_flags <= phy_mgmt_pkg::FLAG_RESET;
      phy_irq <= 1'b0;
      link_q <= 1'b0;
    end
    else
    begin
      event_flags <= next_flags;
      phy_irq <= next_irq;
      link_q <= link.link_ok;
    end
  end

  // writable control registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_enable <= phy_mgmt_pkg::ENABLE_RESET;
      gain <= phy_mgmt_pkg::GAIN_RESET;
      led_cfg <= phy_mgmt_pkg::LED_RESET;
    end
    else
    begin
      if (wr_event)
        irq_enable <= mgmt_wdata[15:8];
      if (wr_gain)
        gain <= mgmt_wdata;
      if (wr_led)
        led_cfg <= mgmt_wdata[7:0];
    end
  end

  // diagnostic capture, no write path exists
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      neg_fail_flag <= 1'b0;
      diag_live <= '0;
    end
    else
    begin
      neg_fail_flag <= next_neg_fail;
      diag_live <= diag;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mgmt_rdata <= phy_mgmt_pkg::RDATA_ZERO;
      mgmt_rvalid <= 1'b0;
    end
    else
    begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd)
        mgmt_rdata <= next_rdata;
    end
  end

  // blink phase generator
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      blink_cnt <= BLINK_ZERO;
      blink_phase <= 1'b0;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      if (blink_wrap)
        blink_phase <= ~blink_phase;
    end
  end

  // registered lamp and gain outputs
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_lamp_a <= 1'b0;
      status_lamp_b <= 1'b0;
      tx_gain_setting <= phy_mgmt_pkg::GAIN_RESET;
    end
    else
    begin
      status_lamp_a <= next_lamp[0];
      status_lamp_b <= next_lamp[1];
      tx_gain_setting <= gain;
    end
  end

  // checks on the register behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // event register read access
  sequence s_event_read;
    mgmt_rd && mgmt_addr == phy_mgmt_pkg::ADDR_EVENT;
  endsequence

  // quiet cycle with no event source active
  sequence s_quiet;
    events == '0 && !(link_q && !link.link_ok);
  endsequence

  property p_rx_error;
    events.rx_error |=> event_flags[phy_mgmt_pkg::BIT_RX_ERROR];
  endproperty
  a_rx_error: assert property (p_rx_error) else $error("rx error flag not set");

  // flag stays up until the event register is read
  property p_rx_hold;
    (event_flags[phy_mgmt_pkg::BIT_RX_ERROR] && !(mgmt_rd && mgmt_addr == phy_mgmt_pkg::ADDR_EVENT))
      |=> event_flags[phy_mgmt_pkg::BIT_RX_ERROR];
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx error flag dropped without read");

  property p_page;
    events.page_received |=> event_flags[phy_mgmt_pkg::BIT_PAGE];
  endproperty
  a_page: assert property (p_page) else $error("page flag not set");

  property p_par_fault;
    events.parallel_fault |=> event_flags[phy_mgmt_pkg::BIT_PAR_FAULT];
  endproperty
  a_par_fault: assert property (p_par_fault) else $error("parallel fault flag not set");

  property p_partner_ack;
    events.partner_ack |=> event_flags[phy_mgmt_pkg::BIT_PARTNER_ACK];
  endproperty
  a_partner_ack: assert property (p_partner_ack) else $error("partner ack flag not set");

  property p_link_fall;
    $fell(link.link_ok) |=> event_flags[phy_mgmt_pkg::BIT_LINK_CHANGE];
  endproperty
  a_link_fall: assert property (p_link_fall) else $error("link change flag not set on failure");

  property p_link_rise;
    ($rose(link.link_ok) && !event_flags[phy_mgmt_pkg::BIT_LINK_CHANGE])
      |=> !event_flags[phy_mgmt_pkg::BIT_LINK_CHANGE];
  endproperty
  a_link_rise: assert property (p_link_rise) else $error("link change flag set on recovery");

  property p_remote;
    events.remote_fault |=> event_flags[phy_mgmt_pkg::BIT_REMOTE_FAULT];
  endproperty
  a_remote: assert property (p_remote) else $error("remote fault flag not set");

  property p_neg_done;
    events.negotiation_done |=> event_flags[phy_mgmt_pkg::BIT_NEG_DONE];
  endproperty
  a_neg_done: assert property (p_neg_done) else $error("negotiation done flag not set");

  property p_clear_on_read;
    (s_event_read and s_quiet) |=> event_flags == phy_mgmt_pkg::FLAG_RESET
      && mgmt_rdata[7:0] == $past(event_flags);
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("read did not clear flags");

  property p_irq;
    (|(event_flags & irq_enable)) ##1 (|(event_flags & irq_enable)) |-> phy_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag did not raise interrupt");

  property p_diag_read;
    (mgmt_rd && mgmt_addr == phy_mgmt_pkg::ADDR_DIAG)
      |=> mgmt_rvalid && mgmt_rdata[7:0] == 8'h00 && mgmt_rdata[15:13] == 3'h0;
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("diagnostic reserved bits not zero");

  property p_gain_write;
    (mgmt_wr && mgmt_addr == phy_mgmt_pkg::ADDR_GAIN) |=> ##1 tx_gain_setting == $past(mgmt_wdata, 2);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain write not applied");

  // gain keeps its value unless written
  property p_gain_hold;
    !(mgmt_wr && mgmt_addr == phy_mgmt_pkg::ADDR_GAIN) |=> gain == $past(gain);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed without write");

  property p_lamp_b;
    (led_cfg[7:4] == phy_mgmt_pkg::LED_SRC_ACTIVITY) |=> status_lamp_b == $past(link.activity);
  endproperty
  a_lamp_b: assert property (p_lamp_b) else $error("lamp b does not follow activity");

  property p_lamp_a;
    (led_cfg[3:0] == phy_mgmt_pkg::LED_SRC_LINK) |=> status_lamp_a == $past(link.link_ok);
  endproperty
  a_lamp_a: assert property (p_lamp_a) else $error("lamp a does not follow link");

  property p_lamp_reserved;
    (led_cfg[3:0] == phy_mgmt_pkg::LED_SRC_RSVD2) |=> !status_lamp_a;
  endproperty
  a_lamp_reserved: assert property (p_lamp_reserved) else $error("reserved source lit lamp");

  // blink source shows the link level while there is nothing to blink
  property p_lamp_blink;
    (led_cfg[3:0] == phy_mgmt_pkg::LED_SRC_LINK_BLINK && !(link.link_ok && link.activity))
      |=> status_lamp_a == $past(link.link_ok);
  endproperty
  a_lamp_blink: assert property (p_lamp_blink) else $error("blink source lamp wrong");

  property p_led_upper;
    (mgmt_rd && mgmt_addr == phy_mgmt_pkg::ADDR_LED) |=> mgmt_rdata[15:8] == 8'h00;
  endproperty
  a_led_upper: assert property (p_led_upper) else $error("led upper byte not zero");

  property p_led_write;
    (mgmt_wr && mgmt_addr == phy_mgmt_pkg::ADDR_LED) |=> led_cfg == $past(mgmt_wdata[7:0]);
  endproperty
  a_led_write: assert property (p_led_write) else $error("led write not stored");

  property p_set_wins;
    (s_event_read and events.rx_error) |=> event_flags[phy_mgmt_pkg::BIT_RX_ERROR];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under clearing read");

  property p_flag_write;
    (s_quiet and (mgmt_wr && mgmt_addr == phy_mgmt_pkg::ADDR_EVENT && !mgmt_rd))
      |=> event_flags == $past(event_flags);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("write changed event flags");

endmodule : phy_mgmt_event_diag_led_regs

// ### mac_mgmt_model.sv
// management master model standing in for the mac side
`timescale 1ns/1ps
module mac_mgmt_model
(
  // clock
  input wire logic clk,
  // management port toward the registers
  output logic [4:0] mgmt_addr,
  output logic mgmt_rd,
  output logic mgmt_wr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  // idle lines at time zero
  initial
  begin
    mgmt_addr = 5'h1f;
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_wdata = 16'h5a5a;
  end

  // one write strobe; released lines are scrambled so stale values never help
  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    @(negedge clk);
    mgmt_addr = addr;
    mgmt_wdata = data;
    mgmt_wr = 1'b1;
    @(negedge clk);
    mgmt_wr = 1'b0;
    mgmt_addr = ~addr;
    mgmt_wdata = ~data;
  endtask : write_reg

  // one read strobe; answer taken in the cycle its valid pulse stands
  task automatic read_reg(input logic [4:0] addr, output logic [15:0] data, output logic ok);
    @(negedge clk);
    mgmt_addr = addr;
    mgmt_rd = 1'b1;
    @(negedge clk);
    mgmt_rd = 1'b0;
    mgmt_addr = ~addr;
    data = mgmt_rdata;
    ok = mgmt_rvalid;
  endtask : read_reg

  // lamp source update by read-modify-write, upper byte kept, reserved codes refused
  task automatic set_lamps(input logic [3:0] src_b, input logic [3:0] src_a);
    logic [15:0] cur;
    logic ok;
    read_reg(phy_mgmt_pkg::ADDR_LED, cur, ok);
    cur[3:0] = (src_a inside {4'h2, 4'h3, 4'h4}) ? cur[3:0] : src_a;
    cur[7:4] = (src_b inside {4'h2, 4'h3, 4'h4}) ? cur[7:4] : src_b;
    write_reg(phy_mgmt_pkg::ADDR_LED, cur);
  endtask : set_lamps
endmodule : mac_mgmt_model

// ### tb_phy_mgmt_event_diag_led_regs.sv
// self-checking bench for the phy event, diagnostic, gain and lamp registers
`timescale 1ns/1ps
module tb_phy_mgmt_event_diag_led_regs;
  // design connections and bookkeeping
  logic clk;
  logic sys_rst;
  logic [4:0] mgmt_addr;
  logic mgmt_rd;
  logic mgmt_wr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid;
  phy_mgmt_pkg::phy_events_t events;
  phy_mgmt_pkg::link_state_t link;
  phy_mgmt_pkg::diag_state_t diag;
  logic phy_irq;
  logic [15:0] tx_gain_setting;
  logic status_lamp_a;
  logic status_lamp_b;
  logic [15:0] rd_val;
  logic rd_ok;
  int fails;
  int n_checks;
  int flag_bit [7] = '{0, 1, 3, 4, 5, 6, 7};
  logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8};

  // design under test with a short blink
  phy_mgmt_event_diag_led_regs #(.BLINK_HALF_CYCLES(4)) phy_mgmt_event_diag_led_regs_inst (
    .clk(clk), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .events(events),
    .link(link), .diag(diag), .phy_irq(phy_irq), .tx_gain_setting(tx_gain_setting),
    .status_lamp_a(status_lamp_a), .status_lamp_b(status_lamp_b));

  // management master
  mac_mgmt_model mac_mgmt_model_inst (
    .clk(clk), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // word compare
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16

  // single bit compare
  task automatic check1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check1

  // read one register and judge data and valid pulse
  task automatic read_check(input logic [4:0] addr, input logic [15:0] exp);
    mac_mgmt_model_inst.read_reg(addr, rd_val, rd_ok);
    check16(rd_val, exp);
    check1(rd_ok, 1'b1);
  endtask : read_check

  // one-cycle event pulse
  task automatic pulse(input logic [6:0] v);
    @(negedge clk);
    events = v;
    @(negedge clk);
    events = 7'h00;
  endtask : pulse

  // expected lamp level for a source code and link state
  function automatic logic lamp_exp(input logic [3:0] code, input logic [4:0] l);
    case (code)
      4'h0: return l[4];
      4'h1: return l[3];
      4'h5: return l[2];
      4'h6: return l[1];
      4'h7: return l[0];
      default: return l[4] & ~l[3];
    endcase
  endfunction : lamp_exp

  // reset values, unmapped address reads zero
  task automatic test_reset();
    read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h0000);
    read_check(phy_mgmt_pkg::ADDR_DIAG, 16'h0000);
    read_check(phy_mgmt_pkg::ADDR_GAIN, 16'h4000);
    read_check(phy_mgmt_pkg::ADDR_LED, 16'h0010);
    read_check(5'h05, 16'h0000);
    check16(tx_gain_setting, 16'h4000);
    $display("test reset done");
  endtask : test_reset

  // each event sets its own flag, a read clears it
  task automatic test_events();
    for (int i = 0; i < 7; i++)
    begin
      pulse(7'h01 << i);
      read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h0001 << flag_bit[i]);
      read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h0000);
    end
    $display("test events done");
  endtask : test_events

  // only a good to failed link move sets the flag
  task automatic test_link();
    @(negedge clk);
    link.link_ok = 1'b1;
    repeat (3) @(negedge clk);
    read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h0000);
    link.link_ok = 1'b0;
    repeat (3) @(negedge clk);
    read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h0004);
    $display("test link done");
  endtask : test_link

  // enables gate the interrupt; flag writes ignored; event beats a clearing read
  task automatic test_irq();
    mac_mgmt_model_inst.write_reg(phy_mgmt_pkg::ADDR_EVENT, 16'h40ff);
    read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h4000);
    pulse(7'h10);
    repeat (2) @(negedge clk);
    check1(phy_irq, 1'b0);
    read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h4020);
    pulse(7'h20);
    repeat (2) @(negedge clk);
    check1(phy_irq, 1'b1);
    read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h4040);
    repeat (2) @(negedge clk);
    check1(phy_irq, 1'b0);
    fork
      mac_mgmt_model_inst.read_reg(phy_mgmt_pkg::ADDR_EVENT, rd_val, rd_ok);
      pulse(7'h20);
    join
    check16(rd_val, 16'h4000);
    read_check(phy_mgmt_pkg::ADDR_EVENT, 16'h4040);
    $display("test irq done");
  endtask : test_irq

  // diagnostic reporting and read-only, gain write-through
  task automatic test_diag_gain();
    @(negedge clk);
    diag = 5'h0d;
    read_check(phy_mgmt_pkg::ADDR_DIAG, 16'h0d00);
    @(negedge clk);
    diag = 5'h1d;
    @(negedge clk);
    diag = 5'h0d;
    read_check(phy_mgmt_pkg::ADDR_DIAG, 16'h1d00);
    read_check(phy_mgmt_pkg::ADDR_DIAG, 16'h0d00);
    mac_mgmt_model_inst.write_reg(phy_mgmt_pkg::ADDR_DIAG, 16'hffff);
    read_check(phy_mgmt_pkg::ADDR_DIAG, 16'h0d00);
    mac_mgmt_model_inst.write_reg(phy_mgmt_pkg::ADDR_GAIN, 16'h1234);
    read_check(phy_mgmt_pkg::ADDR_GAIN, 16'h1234);
    check16(tx_gain_setting, 16'h1234);
    $display("test diag gain done");
  endtask : test_diag_gain

  // upper byte reads zero, reserved codes dark, every source on both lamps, blink on activity
  task automatic test_lamps();
    int na;
    int nb;
    @(negedge clk);
    link = 5'h1f;
    mac_mgmt_model_inst.write_reg(phy_mgmt_pkg::ADDR_LED, 16'hff32);
    read_check(phy_mgmt_pkg::ADDR_LED, 16'h0032);
    check1(status_lamp_a, 1'b0);
    check1(status_lamp_b, 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      @(negedge clk);
      link = (p == 0) ? 5'h15 : 5'h0a;
      for (int c = 0; c < 6; c++)
      begin
        mac_mgmt_model_inst.set_lamps(codes[c], codes[c]);
        repeat (2) @(negedge clk);
        check1(status_lamp_a, lamp_exp(codes[c], link));
        check1(status_lamp_b, lamp_exp(codes[c], link));
      end
    end
    // link up with activity on source 0x8: half of any 16 cycles lit at a half period of 4
    @(negedge clk);
    link = 5'h18;
    na = 0;
    nb = 0;
    repeat (2) @(negedge clk);
    repeat (16)
    begin
      @(negedge clk);
      na += status_lamp_a;
      nb += status_lamp_b;
    end
    check16(16'(na), 16'h0008);
    check16(16'(nb), 16'h0008);
    $display("test lamps done");
  endtask : test_lamps

  // clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end

  // main sequence
  initial
  begin
    fails = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    events = 7'h00;
    link = 5'h00;
    diag = 5'h00;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    test_reset();
    test_events();
    test_link();
    test_irq();
    test_diag_gain();
    test_lamps();
    close_out();
  end
endmodule : tb_phy_mgmt_event_diag_led_regs
